// ==== core/coc_option.sv ====
// Charger option control register, watchdog and derived mode controls
`timescale 1ns/1ns
`include "coc_map.svh"

// Behaviour
// - Register at 12h, 16 bits, reset E70Eh
// - Watchdog expiry forces charge current to zero
// - Period codes: off, 5, 88, 175 s
// - Restart on current, voltage or period write
// - Bit 15 set, battery only: low power
// - Bit 15 clear, battery only: performance mode
// - Comparator enabled by second-option bits 14/13
// - Auto-off clears limit enable on falling edge of battery-present sense
// - Bit 11 drives adapter good in reverse
// - Bit 10 keeps burst above 25 kHz
// - Bit 9: zero 1200 kHz, one 800 kHz
// - Bit 8 enables pass-through ripple reduction
// - Bit 6 clear allows hiccup on short
module coc_option
	import coc_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SEC = `COC_CLK_HZ,
	parameter int unsigned WD_SEC_1       = `COC_WD_SEC_1,
	parameter int unsigned WD_SEC_2       = `COC_WD_SEC_2,
	parameter int unsigned WD_SEC_3       = `COC_WD_SEC_3
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] rdata_o,
	input  wire logic        charge_values_valid_i,
	input  wire logic        battery_only_i,
	input  wire logic        battery_present_sense_i,
	input  wire logic        reverse_boost_mode_i,
	input  wire logic        adapter_present_i,
	input  wire logic [15:0] second_option_register_i,
	output logic             charge_suspend_o,
	output logic             watchdog_expired_o,
	output logic             low_power_active_o,
	output logic             ldo_off_o,
	output logic             monitors_enable_o,
	output logic             comparator_enable_o,
	output logic             adc_available_o,
	output logic             input_limit_enable_o,
	output logic             adapter_good_output_o,
	output logic             audio_band_avoid_o,
	output logic             switch_frequency_select_o,
	output logic             passthrough_ripple_reduce_o,
	output logic             hiccup_enable_o
);

	// ------------------------------------------------------------
	// Register and watchdog state
	// ------------------------------------------------------------
	logic [15:0]      reg_q;
	logic [15:0]      reg_d;
	logic             bp_q;
	logic [7:0]       sec_q;
	logic [7:0]       sec_d;
	coc_wd_state_type wd_q;
	coc_wd_state_type wd_d;
	logic             tick;
	logic             reload;
	logic             wr_opt;
	logic             wr_cur;
	logic             wr_volt;

	function automatic logic [7:0] period_sec(input logic [1:0] sel);
		case (coc_wd_sel_type'(sel))
			COC_WD_5S:   period_sec = 8'(WD_SEC_1);
			COC_WD_88S:  period_sec = 8'(WD_SEC_2);
			COC_WD_175S: period_sec = 8'(WD_SEC_3);
			default:     period_sec = 8'h00;
		endcase
	endfunction : period_sec

	assign wr_opt  = wr_i && (addr_i == `COC_ADDR_OPTION);
	assign wr_cur  = wr_i && (addr_i == `COC_ADDR_CURRENT);
	assign wr_volt = wr_i && (addr_i == `COC_ADDR_VOLTAGE);
	// Any option write counts; period bits are always carried in it
	assign reload  = wr_cur || wr_volt || wr_opt;

	coc_tick #(
		.CYCLES_PER_SEC(CYCLES_PER_SEC)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clear_i(reload),
		.tick_o (tick)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		reg_d = reg_q;
		if (wr_opt) begin
			reg_d = wdata_i;
		end
		// Hardware clear wins only on the falling edge of the sense pin
		if (reg_q[`COC_BIT_AUTO_OFF] && bp_q && !battery_present_sense_i) begin
			reg_d[`COC_BIT_LIMIT_EN] = 1'b0;
		end
		sec_d = sec_q;
		wd_d  = wd_q;
		case (wd_q)
			COC_WD_RUN: begin
				if (reload) begin
					sec_d = period_sec(wr_opt ? wdata_i[14:13] : reg_q[14:13]);
				end else if (tick && sec_q != 8'h00) begin
					sec_d = sec_q - 8'h01;
					if (sec_q == 8'h01 && reg_q[14:13] != 2'b00) begin
						wd_d = COC_WD_EXPIRED;
					end
				end
			end
			COC_WD_EXPIRED: begin
				if (reload) begin
					sec_d = period_sec(wr_opt ? wdata_i[14:13] : reg_q[14:13]);
					wd_d  = COC_WD_RUN;
				end
			end
			default: begin
				wd_d = COC_WD_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_q <= `COC_RESET_OPTION;
			bp_q  <= 1'b1;
			sec_q <= 8'(`COC_WD_SEC_3);
			wd_q  <= COC_WD_RUN;
		end else begin
			reg_q <= reg_d;
			bp_q  <= battery_present_sense_i;
			sec_q <= sec_d;
			wd_q  <= wd_d;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	logic lp;
	logic cmp_req;
	assign lp      = reg_q[`COC_BIT_LOWPWR] && battery_only_i;
	assign cmp_req = second_option_register_i[`COC_BIT_CMP_A]
		|| second_option_register_i[`COC_BIT_CMP_B];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o                     <= `COC_RESET_OPTION;
			charge_suspend_o            <= 1'b0;
			watchdog_expired_o          <= 1'b0;
			low_power_active_o          <= 1'b0;
			ldo_off_o                   <= 1'b0;
			monitors_enable_o           <= 1'b0;
			comparator_enable_o         <= 1'b0;
			adc_available_o             <= 1'b0;
			input_limit_enable_o        <= 1'b1;
			adapter_good_output_o       <= 1'b0;
			audio_band_avoid_o          <= 1'b1;
			switch_frequency_select_o   <= 1'b1;
			passthrough_ripple_reduce_o <= 1'b1;
			hiccup_enable_o             <= 1'b1;
		end else begin
			rdata_o                     <= reg_d;
			// Resume only once the rewritten values are valid
			charge_suspend_o            <= (wd_d == COC_WD_EXPIRED)
				|| !charge_values_valid_i;
			watchdog_expired_o          <= (wd_d == COC_WD_EXPIRED);
			low_power_active_o          <= lp;
			ldo_off_o                   <= lp;
			monitors_enable_o           <= !lp;
			comparator_enable_o         <= !lp || cmp_req;
			adc_available_o             <= !lp;
			input_limit_enable_o        <= reg_d[`COC_BIT_LIMIT_EN];
			adapter_good_output_o       <= adapter_present_i
				|| (reg_q[`COC_BIT_FLAGS_GOOD] && reverse_boost_mode_i);
			audio_band_avoid_o          <= reg_q[`COC_BIT_AUDIO];
			switch_frequency_select_o   <= reg_q[`COC_BIT_FREQ];
			passthrough_ripple_reduce_o <= reg_q[`COC_BIT_RIPPLE];
			hiccup_enable_o             <= !reg_q[`COC_BIT_HICCUP_DIS];
		end
	end

endmodule : coc_option

// ==== core/coc_map.svh ====
// Address, field positions, reset value and timing counts of the charger option register
`ifndef COC_MAP_SVH
`define COC_MAP_SVH

`define COC_ADDR_OPTION     8'h12
`define COC_ADDR_CURRENT    8'h14
`define COC_ADDR_VOLTAGE    8'h15
`define COC_ADDR_OPTION2    8'h30
`define COC_RESET_OPTION    16'hE70E
`define COC_BIT_LOWPWR      15
`define COC_BIT_WD_HI       14
`define COC_BIT_WD_LO       13
`define COC_BIT_AUTO_OFF    12
`define COC_BIT_FLAGS_GOOD  11
`define COC_BIT_AUDIO       10
`define COC_BIT_FREQ        9
`define COC_BIT_RIPPLE      8
`define COC_BIT_HICCUP_DIS  6
`define COC_BIT_LIMIT_EN    1
`define COC_BIT_CMP_A       14
`define COC_BIT_CMP_B       13
`define COC_CLK_HZ          125000000
`define COC_WD_SEC_1        5
`define COC_WD_SEC_2        88
`define COC_WD_SEC_3        175

`endif

// ==== core/coc_pkg.sv ====
// Types shared by the charger option control block
package coc_pkg;

	typedef enum logic [1:0] {
		COC_WD_OFF,
		COC_WD_5S,
		COC_WD_88S,
		COC_WD_175S
	} coc_wd_sel_type;

	typedef enum logic {
		COC_WD_RUN,
		COC_WD_EXPIRED
	} coc_wd_state_type;

endpackage : coc_pkg

// ==== core/coc_tick.sv ====
// Divider producing a one-cycle pulse once per second
`timescale 1ns/1ns
`include "coc_map.svh"

module coc_tick
	import coc_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SEC = `COC_CLK_HZ
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic clear_i,
	output logic      tick_o
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        tick_d;
	logic        tick_q;

	// Restart on clear so a full period always follows a reload
	always_comb begin
		cnt_d  = cnt_q + 32'h1;
		tick_d = 1'b0;
		if (clear_i) begin
			cnt_d = 32'h0;
		end else if (cnt_q >= CYCLES_PER_SEC - 1) begin
			cnt_d  = 32'h0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q  <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule : coc_tick

// ==== tb/coc_option_properties.sv ====
// Assertions on the charger option control ports
`timescale 1ns/1ns
module coc_option_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wr_i,
	input wire logic [7:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] rdata_o,
	input wire logic        battery_only_i,
	input wire logic        battery_present_sense_i,
	input wire logic [15:0] second_option_register_i,
	input wire logic        charge_suspend_o,
	input wire logic        watchdog_expired_o,
	input wire logic        low_power_active_o,
	input wire logic        comparator_enable_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_opt_wr;
		wr_i && addr_i == 8'h12;
	endsequence
	sequence s_wd_wr;
		wr_i && (addr_i == 8'h12 || addr_i == 8'h14 || addr_i == 8'h15);
	endsequence
	// Bit 1 left out: the battery-sense clear may win
	property p_store;
		s_opt_wr |=> rdata_o[15:2] == $past(wdata_i[15:2]) && rdata_o[0] == $past(wdata_i[0]);
	endproperty
	a_store: assert property (p_store) else $error("write not stored");
	property p_hold;
		!(wr_i && addr_i == 8'h12) |=> $stable(rdata_o[15:2]) && $stable(rdata_o[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved");
	property p_lowpwr;
		low_power_active_o == $past(rdata_o[15] && battery_only_i);
	endproperty
	a_lowpwr: assert property (p_lowpwr) else $error("low power wrong");
	// Reset value of the comparator enable is not derived from the inputs
	property p_cmp;
		!$past(rst_i) |-> comparator_enable_o == $past(!(rdata_o[15] && battery_only_i)
			|| second_option_register_i[14] || second_option_register_i[13]);
	endproperty
	a_cmp: assert property (p_cmp) else $error("comparator wrong");
	property p_auto;
		rdata_o[12] && $fell(battery_present_sense_i) |-> ##[1:3] !rdata_o[1];
	endproperty
	a_auto: assert property (p_auto) else $error("limit not cleared");
	property p_wd_off;
		$rose(watchdog_expired_o) |-> $past(rdata_o[14:13]) != 2'b00;
	endproperty
	a_wd_off: assert property (p_wd_off) else $error("expiry while off");
	property p_susp;
		$rose(watchdog_expired_o) |-> ##[0:1] charge_suspend_o;
	endproperty
	a_susp: assert property (p_susp) else $error("no suspend");
	property p_restart;
		s_wd_wr |-> ##2 !watchdog_expired_o;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
endmodule : coc_option_properties

bind coc_option coc_option_properties u_props (.*);

// ==== tb/coc_host.sv ====
// Host model issuing register writes
`timescale 1ns/1ns
module coc_host (
	input  wire logic        clk_i,
	output logic             wr_o,
	output logic      [7:0]  addr_o,
	output logic      [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// Idle bus shows inverted values so stale data never looks valid
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : put
endmodule : coc_host

// ==== tb/coc_option_tb.sv ====
// Self-checking bench of the charger option control block
`timescale 1ns/1ns
module coc_option_tb;
	localparam int CPS = 10;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ok = 1'b1;
	logic        bat = 1'b0;
	logic        sns = 1'b1;
	logic        rev = 1'b0;
	logic        adp = 1'b0;
	logic [15:0] op2 = 16'h0000;
	logic        wr;
	logic [7:0]  addr;
	logic [15:0] wd, rd;
	logic        susp, expd, lowp, cmp;
	logic        ldo, mon, adc, lim, good, aud, frq, rip, hic;
	int          num_errors = 0;
	int          cmp_count = 0;
	coc_host u_host (.clk_i(clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wd));
	coc_option #(.CYCLES_PER_SEC(CPS)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr),
		.addr_i(addr), .wdata_i(wd), .rdata_o(rd), .charge_values_valid_i(ok),
		.battery_only_i(bat), .battery_present_sense_i(sns), .reverse_boost_mode_i(rev),
		.adapter_present_i(adp), .second_option_register_i(op2), .charge_suspend_o(susp),
		.watchdog_expired_o(expd), .low_power_active_o(lowp), .ldo_off_o(ldo),
		.monitors_enable_o(mon), .comparator_enable_o(cmp), .adc_available_o(adc),
		.input_limit_enable_o(lim), .adapter_good_output_o(good), .audio_band_avoid_o(aud),
		.switch_frequency_select_o(frq), .passthrough_ripple_reduce_o(rip),
		.hiccup_enable_o(hic));
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask : chk
	function automatic logic [9:0] exp_mode(input logic [15:0] r, input logic b,
		input logic rv, input logic ad, input logic [15:0] o2);
		logic lp;
		lp = r[15] & b;
		return {lp, !lp, !lp, !lp | o2[14] | o2[13], r[1], ad | (r[11] & rv), r[10], r[9],
			r[8], !r[6]};
	endfunction : exp_mode
	function automatic int wd_cyc(input int c);
		return c == 1 ? 5 * CPS : c == 2 ? 88 * CPS : c == 3 ? 175 * CPS : 100;
	endfunction : wd_cyc
	task automatic wait_exp(input int lim, output int n);
		n = 0;
		while (expd !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_exp
	task automatic end_sim;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		int n, t;
		logic [15:0] d;
		n = $urandom(16);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("reset", 16'hE70E, rd);
		chk("reset modes", 16'h002F, {6'h00, ldo, mon, adc, cmp, lim, good, aud, frq, rip, hic});
		for (int k = 0; k < 15; k++) begin
			// First passes: low power, each comparator request, reverse boost
			d = (16'($urandom) & 16'hEFFF) | ((k < 3) ? 16'h8800 : 16'h0000);
			bat <= (k < 3) ? 1'b1 : 1'($urandom);
			rev <= (k < 3) ? 1'b1 : 1'($urandom);
			adp <= (k < 3) ? 1'b0 : 1'($urandom);
			op2 <= (k < 3) ? 16'(k << 13) : 16'($urandom);
			u_host.put(8'h12, d);
			@(posedge clk_i);
			chk("option", d, rd);
			@(posedge clk_i);
			chk("low power", {15'h0000, d[15] & bat}, {15'h0000, lowp});
			chk("modes", {6'h00, exp_mode(d, bat, rev, adp, op2)}, {6'h00, ldo, mon, adc, cmp, lim, good, aud, frq, rip, hic});
			u_host.put(8'h20 | (8'($urandom) & 8'h0F), ~d);
			@(posedge clk_i);
			chk("unmapped", d, rd);
		end
		for (int c = 0; c < 4; c++) begin
			u_host.put(8'h12, {1'b0, c[1:0], 13'h0002});
			t = wd_cyc(c);
			wait_exp(t + CPS + 5, n);
			chk("expired", {15'h0000, c != 0}, {15'h0000, expd});
			chk("period", 1, c == 0 || (n >= t - CPS && n <= t + CPS));
			chk("suspend", {15'h0000, c != 0}, {15'h0000, susp});
			ok <= 1'b0;
			u_host.put(8'h14, 16'h0400);
			repeat (2) @(posedge clk_i);
			chk("invalid", 1, susp);
			ok <= 1'b1;
			repeat (2) @(posedge clk_i);
			chk("resume", 0, susp);
		end
		u_host.put(8'h12, 16'h2002);
		repeat (3 * CPS) @(posedge clk_i);
		u_host.put(8'h15, 16'h1068);
		wait_exp(8 * CPS, n);
		chk("reload", 1, n >= 4 * CPS && expd === 1'b1);
		u_host.put(8'h12, 16'h1002);
		sns <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("auto off", 16'h1000, rd);
		sns <= 1'b1;
		u_host.put(8'h12, 16'h1002);
		@(posedge clk_i);
		chk("re-enable", 16'h1002, rd);
		u_host.put(8'h12, 16'h0002);
		sns <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("no auto off", 16'h0002, rd);
		end_sim();
	end
endmodule : coc_option_tb
